// *** design/dradr_pkg.sv ***
// Shared constants and types for the display-RAM addressing command decoder.
// Assumes bytes arrive one at a time from the host interface front end.
package dradr_pkg;

   // ---------------------------------------------------------------
   // Opcodes and opcode fields
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_MODE = 8'h20;
   localparam logic [7:0] OP_COLWIN = 8'h21;
   localparam logic [7:0] OP_PAGEWIN = 8'h22;
   localparam logic [3:0] GRP_COL_LO = 4'h0;
   localparam logic [3:0] GRP_COL_HI = 4'h1;
   localparam logic [4:0] GRP_PAGE = 5'h16;

   // ---------------------------------------------------------------
   // Field positions and widths
   // ---------------------------------------------------------------
   localparam int OPC_MSB = 7;
   localparam int NIB_W = 4;
   localparam int COL_W = 7;
   localparam int PAGE_W = 3;
   localparam int MODE_W = 2;

   // ---------------------------------------------------------------
   // Addressing modes and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_HORIZ = 2'h0;
   localparam logic [1:0] MODE_VERT = 2'h1;
   localparam logic [1:0] MODE_PAGE = 2'h2;
   localparam logic [1:0] MODE_BAD = 2'h3;
   localparam logic [1:0] RST_MODE = MODE_PAGE;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [6:0] RST_COL_START = 7'h00;
   localparam logic [6:0] RST_COL_END = 7'h7f;
   localparam logic [2:0] RST_PAGE_START = 3'h0;
   localparam logic [2:0] RST_PAGE_END = 3'h7;

   typedef enum logic [2:0] {
      OPC_NONE, OPC_COL_LO, OPC_COL_HI, OPC_MODE, OPC_COLWIN, OPC_PAGEWIN, OPC_PAGE
   } dradr_op_t;

   typedef enum {
      ST_IDLE, ST_MODE_ARG, ST_COL_START, ST_COL_END, ST_PAGE_START, ST_PAGE_END
   } dradr_state_t;

   typedef struct packed {
      logic [6:0] col_start;
      logic [6:0] col_end;
      logic [2:0] page_start;
      logic [2:0] page_end;
   } dradr_win_t;

   typedef struct packed {
      logic [3:0] col_hi;
      logic [3:0] col_lo;
      logic [2:0] page;
   } dradr_pgptr_t;

endpackage : dradr_pkg

// *** design/dradr_decode.sv ***
// Opcode classifier for the addressing command group.
// Assumes the byte is a command byte; the caller qualifies it.
`timescale 1ns/100ps
module dradr_decode (
   input wire logic [7:0] byte_i,
   output dradr_pkg::dradr_op_t op_o
);

   wire is_lo = (byte_i[dradr_pkg::OPC_MSB:dradr_pkg::NIB_W] == dradr_pkg::GRP_COL_LO);
   wire is_hi = (byte_i[dradr_pkg::OPC_MSB:dradr_pkg::NIB_W] == dradr_pkg::GRP_COL_HI);
   wire is_pg = (byte_i[dradr_pkg::OPC_MSB:dradr_pkg::PAGE_W] == dradr_pkg::GRP_PAGE);
   wire is_md = (byte_i == dradr_pkg::OP_MODE);
   wire is_cw = (byte_i == dradr_pkg::OP_COLWIN);
   wire is_pw = (byte_i == dradr_pkg::OP_PAGEWIN);

   assign op_o = is_lo ? dradr_pkg::OPC_COL_LO :
                 is_hi ? dradr_pkg::OPC_COL_HI :
                 is_md ? dradr_pkg::OPC_MODE :
                 is_cw ? dradr_pkg::OPC_COLWIN :
                 is_pw ? dradr_pkg::OPC_PAGEWIN :
                 is_pg ? dradr_pkg::OPC_PAGE : dradr_pkg::OPC_NONE;

endmodule : dradr_decode

// *** design/dradr_core.sv ***
// Addressing command decoder: addressing mode, write window, page pointer.
// Assumes one byte per valid cycle and a lock level from the command unit.
//
// What this block does
// - Opcodes 00h-0Fh load page-mode column low nibble.
// - Opcodes 10h-1Fh load page-mode column high nibble.
// - Both column nibbles are zero after reset.
// - Nibble commands take effect only in page mode.
// - 20h plus argument selects mode; 11b rejected.
// - 21h sets column start/end, reset 0/127.
// - 22h sets page start/end, reset 0/7.
// - Window commands take effect only horizontal/vertical.
// - Opcodes B0h-B7h set page-mode page start.
// - Locked interface ignores every addressing command.
`timescale 1ns/100ps
module dradr_core (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_i,
   input wire logic dc_i,
   input wire logic lock_i,
   output logic [1:0] addr_mode_o,
   output dradr_pkg::dradr_win_t win_o,
   output dradr_pkg::dradr_pgptr_t pgptr_o,
   output logic arg_pending_o
);

   // ---------------------------------------------------------------
   // Byte qualification and decode
   // ---------------------------------------------------------------
   dradr_pkg::dradr_op_t op;
   dradr_pkg::dradr_state_t state_r, state_nxt;
   logic [1:0] mode_r, mode_nxt;
   dradr_pkg::dradr_win_t win_r, win_nxt;
   dradr_pkg::dradr_pgptr_t pg_r, pg_nxt;

   // Data bytes and bytes sent while locked are decoded but never taken.
   wire take = byte_valid_i & ~dc_i & ~lock_i;
   wire page_mode = (mode_r == dradr_pkg::MODE_PAGE);
   wire idle = (state_r == dradr_pkg::ST_IDLE);

   // Only the low bits of an argument count; bit 7 of a column lies outside 0..127.
   wire [dradr_pkg::NIB_W-1:0] arg_nib = byte_i[dradr_pkg::NIB_W-1:0];
   wire [dradr_pkg::COL_W-1:0] arg_col = byte_i[dradr_pkg::COL_W-1:0];
   wire [dradr_pkg::PAGE_W-1:0] arg_page = byte_i[dradr_pkg::PAGE_W-1:0];
   wire [dradr_pkg::MODE_W-1:0] arg_mode = byte_i[dradr_pkg::MODE_W-1:0];
   wire mode_ok = (arg_mode != dradr_pkg::MODE_BAD);

   dradr_decode dradr_decode_inst (
      .byte_i(byte_i),
      .op_o(op)
   );

   // ---------------------------------------------------------------
   // Next state and field updates
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      win_nxt = win_r;
      pg_nxt = pg_r;
      if (take) begin
         case (state_r)
            dradr_pkg::ST_IDLE: begin
               case (op)
                  dradr_pkg::OPC_COL_LO: begin
                     if (page_mode) pg_nxt.col_lo = arg_nib;
                  end
                  dradr_pkg::OPC_COL_HI: begin
                     if (page_mode) pg_nxt.col_hi = arg_nib;
                  end
                  dradr_pkg::OPC_PAGE: begin
                     if (page_mode) pg_nxt.page = arg_page;
                  end
                  dradr_pkg::OPC_MODE: begin
                     state_nxt = dradr_pkg::ST_MODE_ARG;
                  end
                  dradr_pkg::OPC_COLWIN: begin
                     state_nxt = dradr_pkg::ST_COL_START;
                  end
                  dradr_pkg::OPC_PAGEWIN: begin
                     state_nxt = dradr_pkg::ST_PAGE_START;
                  end
                  default: begin
                     state_nxt = dradr_pkg::ST_IDLE;
                  end
               endcase
            end
            dradr_pkg::ST_MODE_ARG: begin
               // An invalid selection keeps the current mode.
               if (mode_ok) mode_nxt = arg_mode;
               state_nxt = dradr_pkg::ST_IDLE;
            end
            dradr_pkg::ST_COL_START: begin
               // Page mode still consumes the arguments, so the byte stream stays aligned.
               if (!page_mode) win_nxt.col_start = arg_col;
               state_nxt = dradr_pkg::ST_COL_END;
            end
            dradr_pkg::ST_COL_END: begin
               if (!page_mode) win_nxt.col_end = arg_col;
               state_nxt = dradr_pkg::ST_IDLE;
            end
            dradr_pkg::ST_PAGE_START: begin
               if (!page_mode) win_nxt.page_start = arg_page;
               state_nxt = dradr_pkg::ST_PAGE_END;
            end
            dradr_pkg::ST_PAGE_END: begin
               if (!page_mode) win_nxt.page_end = arg_page;
               state_nxt = dradr_pkg::ST_IDLE;
            end
            default: begin
               state_nxt = dradr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= dradr_pkg::ST_IDLE;
         mode_r <= dradr_pkg::RST_MODE;
         win_r <= {dradr_pkg::RST_COL_START, dradr_pkg::RST_COL_END,
                   dradr_pkg::RST_PAGE_START, dradr_pkg::RST_PAGE_END};
         pg_r <= {dradr_pkg::RST_NIBBLE, dradr_pkg::RST_NIBBLE, dradr_pkg::RST_PAGE_START};
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         win_r <= win_nxt;
         pg_r <= pg_nxt;
      end
   end

   assign addr_mode_o = mode_r;
   assign win_o = win_r;
   assign pgptr_o = pg_r;
   assign arg_pending_o = ~idle;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Marks the first clock edge after reset release.
   logic first_r;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) first_r <= 1'b1;
      else first_r <= 1'b0;
   end

   chk_reset_nibbles: assert property (@(posedge clock_i) disable iff (!nrst_i)
      first_r |-> (pgptr_o.col_lo == dradr_pkg::RST_NIBBLE
                   && pgptr_o.col_hi == dradr_pkg::RST_NIBBLE
                   && addr_mode_o == dradr_pkg::RST_MODE))
      else $error("nibbles or mode not at reset value");

   chk_low_nibble: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && idle && page_mode && byte_i[7:4] == 4'h0)
      |=> (pgptr_o.col_lo == $past(byte_i[3:0]) && $stable(pgptr_o.col_hi)))
      else $error("low column nibble not loaded");

   chk_high_nibble: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && idle && page_mode && byte_i[7:4] == 4'h1)
      |=> (pgptr_o.col_hi == $past(byte_i[3:0]) && $stable(pgptr_o.col_lo)))
      else $error("high column nibble not loaded");

   chk_nibble_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (!page_mode && idle) |=> $stable(pgptr_o))
      else $error("page pointer moved outside page mode");

   chk_mode_select: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && byte_i == 8'h20 && idle) ##1 (take && byte_i[1:0] != 2'h3)
      |=> (addr_mode_o == $past(byte_i[1:0]) && arg_pending_o == 1'b0))
      else $error("mode argument not applied");

   chk_mode_invalid: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (state_r == dradr_pkg::ST_MODE_ARG && take && byte_i[1:0] == 2'h3) |=> $stable(addr_mode_o))
      else $error("invalid mode was accepted");

   chk_col_window: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && idle && byte_i == 8'h21 && !page_mode) ##1 take ##1 take
      |=> (win_o.col_start == $past(byte_i[6:0], 2) && win_o.col_end == $past(byte_i[6:0])))
      else $error("column window not applied");

   chk_page_window: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && idle && byte_i == 8'h22 && !page_mode) ##1 take ##1 take
      |=> (win_o.page_start == $past(byte_i[2:0], 2) && win_o.page_end == $past(byte_i[2:0])))
      else $error("page window not applied");

   chk_window_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
      page_mode |=> $stable(win_o))
      else $error("window moved in page mode");

   chk_page_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && idle && page_mode && byte_i[7:3] == 5'h16) |=> pgptr_o.page == $past(byte_i[2:0]))
      else $error("page start not loaded");

   chk_lock_ignore: assert property (@(posedge clock_i) disable iff (!nrst_i)
      lock_i |=> ($stable(addr_mode_o) && $stable(win_o) && $stable(pgptr_o)
                  && $stable(arg_pending_o)))
      else $error("locked interface changed state");

   chk_data_ignore: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (byte_valid_i && dc_i) |=> ($stable(addr_mode_o) && $stable(win_o) && $stable(pgptr_o)
                                  && $stable(arg_pending_o)))
      else $error("display data byte changed addressing state");

   chk_arg_wait: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && idle && (byte_i == 8'h20 || byte_i == 8'h21 || byte_i == 8'h22))
      |=> arg_pending_o)
      else $error("argument not awaited after opcode");

   chk_second_arg: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && (state_r == dradr_pkg::ST_COL_START || state_r == dradr_pkg::ST_PAGE_START))
      |=> arg_pending_o)
      else $error("second window argument not awaited");

   chk_reset_win: assert property (@(posedge clock_i) disable iff (!nrst_i)
      first_r |-> (win_o.col_start == dradr_pkg::RST_COL_START
                   && win_o.col_end == dradr_pkg::RST_COL_END
                   && win_o.page_start == dradr_pkg::RST_PAGE_START
                   && win_o.page_end == dradr_pkg::RST_PAGE_END && !arg_pending_o))
      else $error("window not at reset value");

endmodule : dradr_core

// *** sim/dradr_host.sv ***
// Host model: drives command and data bytes into the decoder, one byte per clock.
// Assumes the bench calls send back to back and idle before it stops.
`timescale 1ns/100ps
module dradr_host (
   input wire logic clock_i,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   output logic dc_o,
   output logic lock_o
);
   initial begin
      byte_valid_o = 1'b0;
      byte_o = 8'h00;
      dc_o = 1'b1;
      lock_o = 1'b0;
   end
   task automatic send(input logic [7:0] b, input logic dc, input logic lk);
      @(posedge clock_i);
      #1;
      byte_valid_o = 1'b1;
      byte_o = b;
      dc_o = dc;
      lock_o = lk;
   endtask : send
   // Idle lines carry the inverse of the last byte, so stale sampling shows up.
   task automatic idle();
      @(posedge clock_i);
      #1;
      byte_valid_o = 1'b0;
      byte_o = ~byte_o;
      dc_o = ~dc_o;
   endtask : idle
endmodule : dradr_host

// *** sim/display_ram_address_commands_bench.sv ***
// Bench for the addressing command decoder: reference model, scoreboard, test sequence.
// Assumes the host model drives the byte port and the decoder checks itself.
`timescale 1ns/100ps
module display_ram_address_commands_bench;
   logic clock;
   logic rst_n;
   logic byte_valid;
   logic [7:0] byte_w;
   logic dc;
   logic lock;
   logic [1:0] addr_mode;
   dradr_pkg::dradr_win_t win;
   dradr_pkg::dradr_pgptr_t pgptr;
   logic arg_pending;
   logic took_r;
   logic [1:0] m;
   dradr_pkg::dradr_win_t w;
   dradr_pkg::dradr_pgptr_t p;
   int st;
   logic [33:0] q[$];
   logic [33:0] note;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [7:0] s1 [11] = '{8'h0a, 8'h1f, 8'hb5, 8'h13, 8'h21, 8'h10, 8'h20, 8'h22, 8'h01,
      8'h02, 8'h07};
   logic [7:0] s2 [18] = '{8'h20, 8'h00, 8'h03, 8'h1c, 8'hb2, 8'h21, 8'h85, 8'h40, 8'h22,
      8'hfb, 8'h0e, 8'h20, 8'hff, 8'h20, 8'h01, 8'h21, 8'h00, 8'h7f};
   dradr_core dradr_core_inst (.clock_i(clock), .nrst_i(rst_n), .byte_valid_i(byte_valid),
      .byte_i(byte_w), .dc_i(dc), .lock_i(lock), .addr_mode_o(addr_mode), .win_o(win),
      .pgptr_o(pgptr), .arg_pending_o(arg_pending));
   dradr_host dradr_host_inst (.clock_i(clock), .byte_valid_o(byte_valid), .byte_o(byte_w),
      .dc_o(dc), .lock_o(lock));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // ---
   // Reference model; a note is queued for every byte, taken or not.
   // ---
   task automatic put(input logic [7:0] b, input logic d = 1'b0, input logic k = 1'b0);
      if (!d && !k) begin
         case (st)
            0: begin
               if (b[7:4] == 4'h0 && m == 2'h2) p.col_lo = b[3:0];
               if (b[7:4] == 4'h1 && m == 2'h2) p.col_hi = b[3:0];
               if (b[7:3] == 5'h16 && m == 2'h2) p.page = b[2:0];
               st = (b == 8'h20) ? 1 : (b == 8'h21) ? 2 : (b == 8'h22) ? 4 : 0;
            end
            1: begin
               if (b[1:0] != 2'h3) m = b[1:0];
               st = 0;
            end
            default: begin
               if (m != 2'h2) begin
                  if (st == 2) w.col_start = b[6:0];
                  if (st == 3) w.col_end = b[6:0];
                  if (st == 4) w.page_start = b[2:0];
                  if (st == 5) w.page_end = b[2:0];
               end
               st = (st == 2 || st == 4) ? st + 1 : 0;
            end
         endcase
      end
      q.push_back({m, w, p, st != 0});
      dradr_host_inst.send(b, d, k);
   endtask : put
   task automatic drain();
      dradr_host_inst.idle();
      for (int i = 0; i < 8 && q.size() > 0; i++) @(posedge clock);
      if (q.size() > 0) begin
         n_mismatch++;
         test_done();
      end
   endtask : drain
   task automatic do_reset();
      #1 rst_n = 1'b0;
      m = 2'h2;
      w = {7'h00, 7'h7f, 3'h0, 3'h7};
      p = '0;
      st = 0;
      repeat (20) @(posedge clock);
      check(pgptr, p);
      check({addr_mode, win, arg_pending}, {m, w, 1'b0});
      #1 rst_n = 1'b1;
   endtask : do_reset
   always @(posedge clock) took_r <= byte_valid;
   always @(negedge clock) begin
      if (took_r === 1'b1) begin
         note = q.pop_front();
         check(addr_mode, note[33:32]);
         check(win, note[31:12]);
         check(pgptr, note[11:1]);
         check(arg_pending, note[0]);
      end
   end
   // ---
   // Test sequence
   // ---
   initial begin
      rst_n = 1'b0;
      void'($urandom(32'h1cbe));
      do_reset();
      $display("test reset done");
      foreach (s1[i]) put(s1[i]);
      drain();
      $display("test page mode done");
      foreach (s2[i]) put(s2[i]);
      drain();
      $display("test window mode done");
      put(8'h22);
      put(8'h03, 1'b0, 1'b1);
      put(8'h55, 1'b1, 1'b0);
      put(8'h04);
      put(8'h06);
      put(8'h20, 1'b0, 1'b1);
      put(8'h21);
      drain();
      do_reset();
      $display("test lock and reset done");
      repeat (400) put(8'($urandom), $urandom_range(0, 7) == 0, $urandom_range(0, 15) == 0);
      drain();
      $display("test random done");
      test_done();
   end
endmodule : display_ram_address_commands_bench
